// file: rtl/fcor_pkg.sv
/*
  fcor_pkg: register map, field layouts, reset values and state codes
  shared by the flash clock and option block and its two helpers.
  assumes: apb slave with 32-bit data and an 8-bit byte address.
*/
package fcor_pkg;

  // -------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // -------------------------------------------------------------
  localparam int FCOR_ADDR_W = 8;
  localparam logic [7:0] FCOR_RATIO_OFS = 8'h00;
  localparam logic [7:0] FCOR_OPTION_OFS = 8'h04;
  localparam logic [7:0] FCOR_CTRL_OFS = 8'h08;
  localparam logic [7:0] FCOR_STATUS_OFS = 8'h0c;
  localparam logic [7:0] FCOR_KEY_OFS = 8'h10;

  // -------------------------------------------------------------
  // field positions of the control, ratio and status words
  // -------------------------------------------------------------
  localparam int FCOR_CTRL_KEYACC_BIT = 0;
  localparam int FCOR_CTRL_LAUNCH_BIT = 1;
  localparam int FCOR_CTRL_COUNT_LSB = 8;
  localparam int FCOR_RATIO_PRE_BIT = 6;
  localparam int FCOR_STAT_FAULT_BIT = 0;
  localparam int FCOR_STAT_BUSY_BIT = 1;
  localparam int FCOR_STAT_SECURE_BIT = 2;
  localparam int FCOR_STAT_UNLOCK_BIT = 3;

  // -------------------------------------------------------------
  // sizes and codes
  // -------------------------------------------------------------
  localparam int FCOR_PULSE_W = 8;
  localparam int FCOR_DIV_W = 6;
  localparam int FCOR_PRESCALE_DIV = 8;
  localparam int FCOR_KEY_BYTES = 8;
  localparam logic [1:0] FCOR_LOCK_OPEN = 2'b10;
  localparam logic [7:0] FCOR_OPT_RESET = 8'hc3;
  localparam logic [7:0] FCOR_OPT_MASK = 8'hc3;
  localparam logic [7:0] FCOR_RATIO_RESET = 8'h00;

  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    FCOR_PE_IDLE = 3'b001,
    FCOR_PE_ARM = 3'b010,
    FCOR_PE_RUN = 3'b100
  } fcor_pe_e;

  typedef struct packed {
    logic written;
    logic prescale_by_eight;
    logic [FCOR_DIV_W-1:0] div;
  } fcor_ratio_s;

  typedef struct packed {
    logic backdoor_allow;
    logic vector_remap_disable;
    logic [3:0] rsv;
    logic [1:0] lock_state_code;
  } fcor_option_s;

endpackage

// file: rtl/fcor_clkdiv.sv
/*
  fcor_clkdiv: prescaler and divisor that make one strobe per period
  of the nvm timing clock.
  assumes: settings are static while run is high.
*/
`timescale 1ns/1ps
module fcor_clkdiv
  import fcor_pkg::*;
#(
  parameter int DIV_W = FCOR_DIV_W,
  parameter int PRE_DIV = FCOR_PRESCALE_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic prescale_by_eight,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);

  typedef struct packed {
    logic [2:0] pre_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic tick;
  } fcor_div_s;

  fcor_div_s r_reg;
  fcor_div_s r_next;
  logic pre_tick;

  // prescale stage then divide by div plus one
  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    pre_tick = !prescale_by_eight || (r_reg.pre_cnt == 3'(PRE_DIV - 1));
    if (!run) begin
      r_next.pre_cnt = '0;
      r_next.div_cnt = '0;
    end else begin
      r_next.pre_cnt = pre_tick ? 3'h0 : r_reg.pre_cnt + 3'h1;
      if (pre_tick) begin
        if (r_reg.div_cnt == div) begin
          r_next.div_cnt = '0;
          r_next.tick = 1'b1;
        end else begin
          r_next.div_cnt = r_reg.div_cnt + 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;

endmodule

// file: rtl/fcor_keycmp.sv
/*
  fcor_keycmp: compares key bytes written in order with the stored
  unlock phrase; byte 0 sits in bits 7:0 of the phrase.
  assumes: finish is a one-cycle pulse at the end of key entry.
*/
`timescale 1ns/1ps
module fcor_keycmp
  import fcor_pkg::*;
#(
  parameter int KEY_BYTES = FCOR_KEY_BYTES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic byte_we,
  input wire logic [7:0] byte_in,
  input wire logic [8*KEY_BYTES-1:0] phrase,
  input wire logic finish,
  output logic match
);

  typedef struct packed {
    logic [3:0] idx;
    logic mismatch;
    logic match;
  } fcor_key_s;

  fcor_key_s r_reg;
  fcor_key_s r_next;

  // in-order compare, verdict on finish
  always_comb begin
    r_next = r_reg;
    r_next.match = 1'b0;
    if (finish) begin
      r_next.match = (r_reg.idx == 4'(KEY_BYTES)) && !r_reg.mismatch;
      r_next.idx = '0;
      r_next.mismatch = 1'b0;
    end else if (byte_we) begin
      if (r_reg.idx == 4'(KEY_BYTES)) begin
        r_next.mismatch = 1'b1; // extra byte spoils the entry
      end else begin
        if (phrase[8*r_reg.idx +: 8] != byte_in) begin
          r_next.mismatch = 1'b1;
        end
        r_next.idx = r_reg.idx + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign match = r_reg.match;

endmodule

// file: rtl/fcor_top.sv
/*
  fcor_top: flash clock ratio register with its timing divider and
  program/erase pulse sequencer, working option register, backdoor key
  entry and security gate, all behind an apb slave.
  assumes: stored option byte, unlock phrase, debug_access,
  src_unsecured and blank_check_ok come from logic on pclk.
*/
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
module fcor_top
  import fcor_pkg::*;
#(
  parameter int DIV_W = FCOR_DIV_W,
  parameter int PRE_DIV = FCOR_PRESCALE_DIV,
  parameter int KEY_BYTES = FCOR_KEY_BYTES,
  parameter int PULSE_W = FCOR_PULSE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [FCOR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] stored_option_byte,
  input wire logic [8*KEY_BYTES-1:0] stored_unlock_phrase,
  input wire logic debug_access,
  input wire logic blank_check_ok,
  input wire logic src_unsecured,
  output logic pe_enable,
  output logic pe_active,
  output logic pe_done,
  output logic nvm_timing_clock,
  output logic vector_redirect_en,
  output logic secure,
  output logic mem_access_ok
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    fcor_ratio_s ratio;
    fcor_option_s opt;
    logic opt_loaded;
    logic keyacc;
    logic fault;
    logic unlocked;
    fcor_pe_e pe_state;
    logic [PULSE_W-1:0] pulse_left;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pe_enable;
    logic pe_active;
    logic pe_done;
    logic timing_strobe;
    logic remap_en;
    logic secure;
    logic mem_ok;
  } fcor_top_s;

  fcor_top_s r_reg;
  fcor_top_s r_next;

  // -------------------------------------------------------------
  // helpers and decode
  // -------------------------------------------------------------
  logic tick;
  logic key_match;
  logic key_we;
  logic key_finish;
  logic setup;
  logic wr;
  logic hit_ratio;
  logic hit_option;
  logic hit_ctrl;
  logic hit_status;
  logic hit_key;
  logic fault_set;
  logic fault_clr;
  logic launch;
  logic [PULSE_W-1:0] launch_count;
  logic secure_now;

  // timing clock divider, runs once the ratio is loaded
  fcor_clkdiv #(
    .DIV_W(DIV_W),
    .PRE_DIV(PRE_DIV)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(r_reg.ratio.written),
    .prescale_by_eight(r_reg.ratio.prescale_by_eight),
    .div(r_reg.ratio.div),
    .tick(tick)
  );

  // backdoor key comparator
  fcor_keycmp #(
    .KEY_BYTES(KEY_BYTES)
  ) u_key (
    .pclk(pclk),
    .presetn(presetn),
    .byte_we(key_we),
    .byte_in(pwdata[7:0]),
    .phrase(stored_unlock_phrase),
    .finish(key_finish),
    .match(key_match)
  );

  // address decode, one aligned word per register
  always_comb begin
    hit_ratio = 1'b0;
    hit_option = 1'b0;
    hit_ctrl = 1'b0;
    hit_status = 1'b0;
    hit_key = 1'b0;
    if (paddr == FCOR_RATIO_OFS) begin
      hit_ratio = 1'b1;
    end else if (paddr == FCOR_OPTION_OFS) begin
      hit_option = 1'b1;
    end else if (paddr == FCOR_CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (paddr == FCOR_STATUS_OFS) begin
      hit_status = 1'b1;
    end else if (paddr == FCOR_KEY_OFS) begin
      hit_key = 1'b1;
    end
  end

  // bus phases: answer registered in setup, write taken in access
  assign setup = psel && !penable;
  assign wr = psel && penable && r_reg.pready && pwrite && !r_reg.pslverr;

  // write-side strobes
  always_comb begin
    launch = wr && hit_ctrl && pwdata[FCOR_CTRL_LAUNCH_BIT];
    launch_count = pwdata[FCOR_CTRL_COUNT_LSB +: PULSE_W];
    fault_clr = wr && hit_status && pwdata[FCOR_STAT_FAULT_BIT];
    key_finish = wr && hit_ctrl && r_reg.keyacc && !pwdata[FCOR_CTRL_KEYACC_BIT];
    key_we = wr && hit_key && r_reg.keyacc && r_reg.opt.backdoor_allow
      && !debug_access;
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    r_next.pe_done = 1'b0;
    r_next.timing_strobe = 1'b0;
    fault_set = 1'b0;

    // option copy right after reset release
    if (!r_reg.opt_loaded) begin
      r_next.opt = fcor_option_s'(stored_option_byte & FCOR_OPT_MASK);
      r_next.opt_loaded = 1'b1;
    end

    // unlock paths force the lock code open
    if ((key_match && r_reg.opt.backdoor_allow) || blank_check_ok) begin
      r_next.opt.lock_state_code = FCOR_LOCK_OPEN;
    end
    if (key_match && r_reg.opt.backdoor_allow) begin
      r_next.unlocked = 1'b1;
    end

    // read answer prepared in the setup cycle
    if (setup) begin
      r_next.pready = 1'b1;
      r_next.prdata = '0;
      if (hit_ratio) begin
        r_next.prdata[7:0] = r_reg.ratio;
      end else if (hit_option) begin
        r_next.prdata[7:0] = r_reg.opt;
      end else if (hit_ctrl) begin
        r_next.prdata[FCOR_CTRL_KEYACC_BIT] = r_reg.keyacc;
      end else if (hit_status) begin
        r_next.prdata[FCOR_STAT_FAULT_BIT] = r_reg.fault;
        r_next.prdata[FCOR_STAT_BUSY_BIT] = r_reg.pe_state != FCOR_PE_IDLE;
        r_next.prdata[FCOR_STAT_SECURE_BIT] = r_reg.secure;
        r_next.prdata[FCOR_STAT_UNLOCK_BIT] = r_reg.unlocked;
      end else if (!hit_key) begin
        r_next.pslverr = 1'b1; // unmapped address
      end
    end

    // ratio register: one write only, flag set whatever the data
    if (wr && hit_ratio && !r_reg.ratio.written) begin
      r_next.ratio.written = 1'b1;
      r_next.ratio.prescale_by_eight = pwdata[FCOR_RATIO_PRE_BIT];
      r_next.ratio.div = pwdata[DIV_W-1:0];
    end
    // a second write falls through here untouched

    // control register
    if (wr && hit_ctrl) begin
      r_next.keyacc = pwdata[FCOR_CTRL_KEYACC_BIT];
    end

    // program/erase sequencer in whole timing clock periods
    case (r_reg.pe_state)
      FCOR_PE_IDLE: begin
        if (launch) begin
          if (!r_reg.ratio.written || launch_count == '0) begin
            fault_set = 1'b1;
          end else begin
            r_next.pulse_left = launch_count;
            r_next.pe_state = FCOR_PE_ARM;
          end
        end
      end
      FCOR_PE_ARM: begin
        if (launch) begin
          fault_set = 1'b1; // busy, command dropped
        end
        if (tick) begin
          r_next.pe_state = FCOR_PE_RUN; // align to a period edge
        end
      end
      FCOR_PE_RUN: begin
        if (launch) begin
          fault_set = 1'b1;
        end
        if (tick) begin
          r_next.timing_strobe = 1'b1;
          r_next.pulse_left = r_reg.pulse_left - 1'b1;
          if (r_reg.pulse_left == PULSE_W'(1)) begin
            r_next.pe_state = FCOR_PE_IDLE;
            r_next.pe_done = 1'b1;
          end
        end
      end
      default: begin
        r_next.pe_state = FCOR_PE_IDLE;
      end
    endcase

    // access fault: set beats clear
    r_next.fault = (r_reg.fault && !fault_clr) || fault_set;

    // registered outputs
    secure_now = r_next.opt.lock_state_code != FCOR_LOCK_OPEN;
    r_next.secure = secure_now;
    r_next.mem_ok = !secure_now || !src_unsecured;
    r_next.remap_en = !r_next.opt.vector_remap_disable;
    r_next.pe_enable = r_next.ratio.written;
    r_next.pe_active = r_next.pe_state == FCOR_PE_RUN;
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.ratio <= fcor_ratio_s'(FCOR_RATIO_RESET);
      r_reg.opt <= fcor_option_s'(FCOR_OPT_RESET);
      r_reg.pe_state <= FCOR_PE_IDLE;
      r_reg.secure <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // -------------------------------------------------------------
  // outputs, all straight from flip-flops
  // -------------------------------------------------------------
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign pe_enable = r_reg.pe_enable;
  assign pe_active = r_reg.pe_active;
  assign pe_done = r_reg.pe_done;
  assign nvm_timing_clock = r_reg.timing_strobe;
  assign vector_redirect_en = r_reg.remap_en;
  assign secure = r_reg.secure;
  assign mem_access_ok = r_reg.mem_ok;

endmodule

// file: dv/fcor_sva.sv
/*
  fcor_checker: concurrent checks on the ports of fcor_top.
  assumes: bound into every fcor_top, single pclk domain.
*/
`timescale 1ns/1ps
module fcor_checker
  import fcor_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [FCOR_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic src_unsecured,
  input wire logic pe_enable,
  input wire logic pe_active,
  input wire logic pe_done,
  input wire logic secure,
  input wire logic mem_access_ok,
  input wire logic vector_redirect_en
);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  logic [1:0] cnt_reg;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  sequence s_blocked;
    (secure && src_unsecured) [*2];
  endsequence
  // edges since reset release, saturating at three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
    end else if (cnt_reg != 2'h3) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  a_pready_once: assert property (s_setup |=> s_answer) else $error("pready timing wrong");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_unmapped_err: assert property (psel && !penable && paddr > FCOR_KEY_OFS |=> pslverr)
    else $error("unmapped access not refused");
  a_flag_read: assert property (
    psel && !penable && !pwrite && paddr == FCOR_RATIO_OFS |=> prdata[7] == pe_enable)
    else $error("loaded flag read wrong");
  a_flag_sticky: assert property (pe_enable |=> pe_enable)
    else $error("loaded flag dropped");
  a_run_gated: assert property (pe_active |-> pe_enable)
    else $error("operation without loaded flag");
  a_done_end: assert property ($fell(pe_active) |-> pe_done)
    else $error("done missing at end");
  a_done_pulse: assert property (pe_done |=> !pe_done)
    else $error("done too long");
  a_mem_block: assert property (s_blocked |-> !mem_access_ok)
    else $error("secure memory reachable");
  a_remap_fixed: assert property (cnt_reg == 2'h3 |-> $stable(vector_redirect_en))
    else $error("redirect changed");
  a_unlock_holds: assert property (cnt_reg == 2'h3 && !secure |=> !secure)
    else $error("security re-engaged");
endmodule
bind fcor_top fcor_checker u_fcor_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .src_unsecured(src_unsecured), .pe_enable(pe_enable),
  .pe_active(pe_active), .pe_done(pe_done), .secure(secure), .mem_access_ok(mem_access_ok),
  .vector_redirect_en(vector_redirect_en));

// file: dv/fcor_bench.sv
/*
  fcor_bench: scenario tests of fcor_top driven over apb.
  assumes: default parameters, checker bound by its own file.
*/
`timescale 1ns/1ps
module fcor_bench
  import fcor_pkg::*;
;
  // -------------------------------------------------------------
  // stimulus, instance and shared tasks
  // -------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] opt_in = 8'h83;
  logic [63:0] phrase = 64'h0f1e2d3c4b5a6978;
  logic dbg = 1'b0;
  logic blank = 1'b0;
  logic src = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, pe_enable, pe_active, pe_done, tick, redir, secure, mem_ok;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int cmp_count = 0;
  fcor_top u_fcor_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stored_option_byte(opt_in), .stored_unlock_phrase(phrase),
    .debug_access(dbg), .blank_check_ok(blank), .src_unsecured(src), .pe_enable(pe_enable),
    .pe_active(pe_active), .pe_done(pe_done), .nvm_timing_clock(tick),
    .vector_redirect_en(redir), .secure(secure), .mem_access_ok(mem_ok));
  // 25 ns bus clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic tmo(input string s);
    num_errors++;
    $display("[ERR] %s exp answer seen timeout", s);
    give_verdict();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) tmo("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
  endtask
  task automatic key(input logic [63:0] k);
    apb(1'b1, FCOR_CTRL_OFS, 32'h1);
    for (int i = 0; i < 8; i++) apb(1'b1, FCOR_KEY_OFS, {24'h0, k[8*i+:8]});
    apb(1'b1, FCOR_CTRL_OFS, 32'h0);
    settle(4);
  endtask
  // launch n pulses, expect n*per active cycles and strobes per apart
  task automatic meas(input int n, input int per);
    int i, cyc, last, gap, act;
    cyc = 0;
    last = 0;
    gap = 0;
    act = 0;
    apb(1'b1, FCOR_CTRL_OFS, 32'h2 | (n << 8));
    for (i = 0; i < 3000; i++) begin
      @(negedge pclk);
      cyc++;
      if (tick === 1'b1 && pe_active === 1'b1) begin
        if (last > 0) gap = cyc - last;
        last = cyc;
      end
      if (pe_active === 1'b1) act++;
      if (pe_done === 1'b1) break;
    end
    if (i == 3000) tmo("pe_done");
    chk("active_cycles", act, n * per);
    if (n > 1) chk("tick_gap", gap, per);
    $display("launch %0d pulses done", n);
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_boot();
    apb(1'b0, FCOR_OPTION_OFS, 32'h0);
    chk("option", rd, 32'h83);
    chk("secure", secure, 1'b1);
    chk("redirect", redir, 1'b1);
    chk("mem_ok", mem_ok, 1'b0);
    @(posedge pclk);
    src <= 1'b0;
    settle(2);
    chk("mem_secured_src", mem_ok, 1'b1);
    @(posedge pclk);
    src <= 1'b1;
    apb(1'b0, FCOR_RATIO_OFS, 32'h0);
    chk("ratio", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", err, 1'b1);
    $display("boot done");
  endtask
  task automatic t_early();
    apb(1'b1, FCOR_CTRL_OFS, 32'h0202);
    settle(4);
    chk("early_active", pe_active, 1'b0);
    apb(1'b0, FCOR_STATUS_OFS, 32'h0);
    chk("fault", rd[0], 1'b1);
    apb(1'b1, FCOR_STATUS_OFS, 32'h1);
    apb(1'b0, FCOR_STATUS_OFS, 32'h0);
    chk("fault_clr", rd[0], 1'b0);
    $display("early launch done");
  endtask
  task automatic t_once(input logic [7:0] v);
    apb(1'b1, FCOR_RATIO_OFS, {24'h0, v});
    apb(1'b1, FCOR_RATIO_OFS, 32'h05);
    apb(1'b0, FCOR_RATIO_OFS, 32'h0);
    chk("ratio_once", rd, {24'h0, 1'b1, v[6:0]});
    chk("pe_enable", pe_enable, 1'b1);
    $display("ratio write done");
  endtask
  task automatic t_key();
    key(~phrase);
    chk("wrong_key", secure, 1'b1);
    @(posedge pclk);
    dbg <= 1'b1;
    key(phrase);
    @(posedge pclk);
    dbg <= 1'b0;
    chk("debug_key", secure, 1'b1);
    key(phrase);
    chk("good_key", secure, 1'b0);
    chk("mem_open", mem_ok, 1'b1);
    apb(1'b0, FCOR_STATUS_OFS, 32'h0);
    chk("status_open", rd, 32'h8);
    apb(1'b1, FCOR_OPTION_OFS, 32'h0);
    opt_in <= 8'h43;
    apb(1'b0, FCOR_OPTION_OFS, 32'h0);
    chk("lock_open", rd, 32'h82);
    $display("key done");
  endtask
  task automatic t_second();
    do_reset();
    apb(1'b0, FCOR_OPTION_OFS, 32'h0);
    chk("reload", rd, 32'h43);
    chk("no_redirect", redir, 1'b0);
    chk("flag_clear", pe_enable, 1'b0);
    t_once(8'h02);
    meas(1, 3);
    key(phrase);
    chk("key_barred", secure, 1'b1);
    @(posedge pclk);
    blank <= 1'b1;
    @(posedge pclk);
    blank <= 1'b0;
    settle(4);
    chk("blank_open", secure, 1'b0);
    $display("second reset done");
  endtask
  initial begin
    do_reset();
    t_boot();
    t_early();
    t_once(8'h58);
    meas(3, 200);
    t_key();
    t_second();
    give_verdict();
  end
endmodule
